// ===== rtl/macrocell_pkg.sv
// Shared constants for the programmable macrocell array.
// Assumes one 10 MHz system clock and an APB register port.
package macrocell_pkg;

    // Array geometry
    localparam int IN_COUNT       = 12;
    localparam int CELL_COUNT     = 10;
    localparam int SIG_COUNT      = IN_COUNT + CELL_COUNT;
    localparam int TERMS_PER_CELL = 8;
    localparam int TERM_OE_BASE   = CELL_COUNT * TERMS_PER_CELL;
    localparam int TERM_CLEAR     = TERM_OE_BASE + CELL_COUNT;
    localparam int TERM_PRESET    = TERM_CLEAR + 1;
    localparam int TERM_COUNT     = TERM_PRESET + 1;
    localparam int TERM_IDX_W     = 7;
    localparam int SYNC_W         = 2 + 2 * IN_COUNT + 2 * CELL_COUNT;

    // Register byte addresses
    localparam logic [11:0] ADDR_CELL_MODE = 12'h000;
    localparam logic [11:0] ADDR_CELL_POL  = 12'h004;
    localparam logic [11:0] ADDR_SECURE    = 12'h008;
    localparam logic [11:0] ADDR_PRELOAD   = 12'h00c;
    localparam logic [11:0] ADDR_SIG_LO    = 12'h010;
    localparam logic [11:0] ADDR_SIG_HI    = 12'h014;
    localparam logic [11:0] ADDR_STATUS    = 12'h018;
    localparam logic [11:0] ADDR_PINS      = 12'h01c;
    localparam logic [11:0] ADDR_TERM_BASE = 12'h100;
    localparam logic [11:0] ADDR_TERM_END  = 12'h3e0;

    // Field positions
    localparam int SECURE_FUSE_BIT = 0;
    localparam int PRELOAD_VAL_LSB = 0;
    localparam int PRELOAD_SEL_LSB = 16;
    localparam int STATUS_Q_LSB    = 0;
    localparam int STATUS_OE_LSB   = 10;
    localparam int STATUS_POR_BIT  = 20;
    localparam int STATUS_SEC_BIT  = 21;
    localparam int PINS_IN_LSB     = 0;
    localparam int PINS_IO_LSB     = 12;

    // Reset values
    localparam logic [9:0]  CELL_MODE_RST = 10'h000;
    localparam logic [9:0]  CELL_POL_RST  = 10'h000;
    localparam logic [63:0] SIG_RST       = 64'h0;
    localparam logic [21:0] TERM_RST      = 22'h0;

    // Timing
    localparam int CLK_PERIOD_NS    = 100;
    localparam int PWR_RESET_MAX_NS = 1000;
    localparam int PWR_RESET_CYC    = PWR_RESET_MAX_NS / CLK_PERIOD_NS;
    localparam int POR_CNT_W        = 4;

endpackage

// ===== rtl/pin_keeper.sv
// Bus-hold keepers for a group of pins.
// Assumes pin level and drive flag are already synchronised.
module pin_keeper
    import macrocell_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         clk_sys,  // system clock
    input  wire logic         arst_n,   // async reset, active low
    input  wire logic [W-1:0] level,    // pin level while driven
    input  wire logic [W-1:0] driven,   // pin is driven by someone
    output logic      [W-1:0] kept      // level seen by the array
);

    logic [W-1:0] held_reg;
    logic [W-1:0] held_next;

    // A driver overrides at once; the keeper only fills gaps
    for (genvar i = 0; i < W; i++) begin : g_keep
        assign kept[i] = driven[i] ? level[i] : held_reg[i];
    end

    always_comb begin
        held_next = kept;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            held_reg <= '0;
        end else begin
            held_reg <= held_next;
        end
    end

endmodule // pin_keeper

// ===== rtl/macro_cell.sv
// One output macrocell: register, polarity, output enable.
// Assumes array terms come from logic on the same clock.
module macro_cell
    import macrocell_pkg::*;
(
    input  wire logic clk_sys,    // system clock
    input  wire logic arst_n,     // async reset, active low
    input  wire logic sumIn,      // OR of this cell's terms
    input  wire logic oeTerm,     // enable product term
    input  wire logic oePin,      // enable pin, synchronised
    input  wire logic clkEdge,    // rising edge of clock pin
    input  wire logic runOk,      // power-up interval over
    input  wire logic clearTerm,  // async reset product term
    input  wire logic presetTerm, // sync preset product term
    input  wire logic loadEn,     // preload strobe
    input  wire logic loadVal,    // preload value
    input  wire logic regMode,    // 1 registered, 0 combinational
    input  wire logic invert,     // 1 inverts pin polarity
    output logic      q,          // register state
    output logic      padOut,     // pin output level
    output logic      padOe       // pin driver enable
);

    logic q_reg;
    logic q_next;
    logic padOut_reg;
    logic padOut_next;
    logic padOe_reg;
    logic padOe_next;

    always_comb begin
        q_next = q_reg;
        if (clearTerm) begin
            q_next = 1'b0;
        end else if (loadEn) begin
            q_next = loadVal;
        end else if (clkEdge && runOk) begin
            q_next = presetTerm ? 1'b1 : sumIn;
        end
        // Registered path shows the new state, not the array
        padOut_next = (regMode ? q_next : sumIn) ^ invert;
        padOe_next  = oeTerm & oePin;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            q_reg      <= 1'b0;
            padOut_reg <= 1'b0;
            padOe_reg  <= 1'b0;
        end else begin
            q_reg      <= q_next;
            padOut_reg <= padOut_next;
            padOe_reg  <= padOe_next;
        end
    end

    assign q      = q_reg;
    assign padOut = padOut_reg;
    assign padOe  = padOe_reg;

endmodule // macro_cell

// ===== rtl/macrocell_array.sv
// Programmable macrocell array with APB configuration port.
// Assumes pins arrive asynchronously; clock pin is sampled at 10 MHz.
//
// The APB interface to the registers and the address map are this design's own decisions.

module macrocell_array
    import macrocell_pkg::*;
(
    input  wire logic                 clk_sys,    // system clock
    input  wire logic                 arst_n,     // async reset, low
    input  wire logic [11:0]          paddr,      // APB address
    input  wire logic                 psel,       // APB select
    input  wire logic                 penable,    // APB enable
    input  wire logic                 pwrite,     // APB direction
    input  wire logic [31:0]          pwdata,     // APB write data
    output logic      [31:0]          prdata,     // APB read data
    output logic                      pready,     // APB ready
    output logic                      pslverr,    // APB error
    input  wire logic [IN_COUNT-1:0]  dinLevel,   // input pin levels
    input  wire logic [IN_COUNT-1:0]  dinDriven,  // input pins driven
    input  wire logic                 clkPin,     // register clock pin
    input  wire logic                 outEnPin,   // driver enable pin
    input  wire logic [CELL_COUNT-1:0] ioLevel,   // I/O pin levels
    input  wire logic [CELL_COUNT-1:0] ioDriven,  // I/O driven outside
    output logic      [CELL_COUNT-1:0] ioOut,     // I/O output levels
    output logic      [CELL_COUNT-1:0] ioOe       // I/O output enables
);

    // Term decode shared by read and write paths
    function automatic logic isTermAddr(input logic [11:0] a);
        isTermAddr = (a >= ADDR_TERM_BASE) && (a < ADDR_TERM_END);
    endfunction

    function automatic logic [TERM_IDX_W-1:0] termIdx(
        input logic [11:0] a);
        logic [11:0] off;
        off = a - ADDR_TERM_BASE;
        termIdx = off[9:3];
    endfunction

    // A blank term reads as false, so unused terms stay quiet
    function automatic logic termHit(
        input logic [SIG_COUNT-1:0] pickTrue,
        input logic [SIG_COUNT-1:0] pickComp,
        input logic [SIG_COUNT-1:0] sig);
        termHit = (|{pickTrue, pickComp}) &&
                  (&((sig | ~pickTrue) & (~sig | ~pickComp)));
    endfunction

    // Pin synchronisers
    logic [SYNC_W-1:0] syncA_reg;
    logic [SYNC_W-1:0] syncB_reg;
    logic              clkPinOld_reg;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            syncA_reg     <= '0;
            syncB_reg     <= '0;
            clkPinOld_reg <= 1'b0;
        end else begin
            syncA_reg     <= {clkPin, outEnPin, dinLevel, dinDriven,
                              ioLevel, ioDriven};
            syncB_reg     <= syncA_reg;
            clkPinOld_reg <= syncB_reg[SYNC_W-1];
        end
    end

    logic                  clkPinS;
    logic                  outEnS;
    logic [IN_COUNT-1:0]   dinLevelS;
    logic [IN_COUNT-1:0]   dinDrivenS;
    logic [CELL_COUNT-1:0] ioLevelS;
    logic [CELL_COUNT-1:0] ioDrivenS;
    logic                  clkEdge;

    assign {clkPinS, outEnS, dinLevelS, dinDrivenS,
            ioLevelS, ioDrivenS} = syncB_reg;
    assign clkEdge = clkPinS & ~clkPinOld_reg;

    // Configuration and status state
    logic [CELL_COUNT-1:0] cellMode_reg;
    logic [CELL_COUNT-1:0] cellMode_next;
    logic [CELL_COUNT-1:0] cellPol_reg;
    logic [CELL_COUNT-1:0] cellPol_next;
    logic                  secured_reg;
    logic                  secured_next;
    logic [63:0]           sig_reg;
    logic [63:0]           sig_next;
    logic [POR_CNT_W-1:0]  porCnt_reg;
    logic [POR_CNT_W-1:0]  porCnt_next;
    logic [SIG_COUNT-1:0]  termTrue_reg [TERM_COUNT];
    logic [SIG_COUNT-1:0]  termTrue_next [TERM_COUNT];
    logic [SIG_COUNT-1:0]  termComp_reg [TERM_COUNT];
    logic [SIG_COUNT-1:0]  termComp_next [TERM_COUNT];
    logic [31:0]           prdata_reg;
    logic [31:0]           prdata_next;
    logic                  pready_reg;
    logic                  pready_next;
    logic                  pslverr_reg;
    logic                  pslverr_next;

    logic                  porBusy;
    logic                  wrEn;
    logic                  preloadWr;
    logic [CELL_COUNT-1:0] loadEn;
    logic [CELL_COUNT-1:0] cellQ;
    logic [CELL_COUNT-1:0] cellOut;
    logic [CELL_COUNT-1:0] cellOe;

    // Power-up interval: the clock pin is ignored until it ends
    assign porBusy = porCnt_reg < POR_CNT_W'(PWR_RESET_CYC);

    // Write takes effect only at the completing access edge
    assign wrEn = psel & penable & pwrite & pready_reg;
    assign preloadWr = wrEn && (paddr == ADDR_PRELOAD) && !secured_reg;

    // Keepers: an I/O pin we drive is held at our own level
    logic [IN_COUNT-1:0]   dinKept;
    logic [CELL_COUNT-1:0] ioKept;

    pin_keeper #(
        .W (IN_COUNT)
    ) u_keep_in (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .level   (dinLevelS),
        .driven  (dinDrivenS),
        .kept    (dinKept)
    );

    pin_keeper #(
        .W (CELL_COUNT)
    ) u_keep_io (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .level   ((ioLevelS & ~cellOe) | (cellOut & cellOe)),
        .driven  (ioDrivenS | cellOe),
        .kept    (ioKept)
    );

    // Array signals: feedback is the register when registered,
    // otherwise the pin
    logic [CELL_COUNT-1:0] feedback;
    logic [SIG_COUNT-1:0]  arraySig;
    logic [TERM_COUNT-1:0] termVal;

    assign feedback = (cellQ & cellMode_reg) | (ioKept & ~cellMode_reg);
    assign arraySig = {feedback, dinKept};

    for (genvar t = 0; t < TERM_COUNT; t++) begin : g_term
        assign termVal[t] = termHit(termTrue_reg[t], termComp_reg[t],
                                    arraySig);
    end

    // Preload selects cells individually
    for (genvar m = 0; m < CELL_COUNT; m++) begin : g_cell
        assign loadEn[m] = preloadWr && pwdata[PRELOAD_SEL_LSB + m];

        macro_cell u_cell (
            .clk_sys    (clk_sys),
            .arst_n     (arst_n),
            .sumIn      (|termVal[m*TERMS_PER_CELL +: TERMS_PER_CELL]),
            .oeTerm     (termVal[TERM_OE_BASE + m]),
            .oePin      (outEnS),
            .clkEdge    (clkEdge),
            .runOk      (!porBusy),
            .clearTerm  (termVal[TERM_CLEAR]),
            .presetTerm (termVal[TERM_PRESET]),
            .loadEn     (loadEn[m]),
            .loadVal    (pwdata[PRELOAD_VAL_LSB + m]),
            .regMode    (cellMode_reg[m]),
            .invert     (cellPol_reg[m]),
            .q          (cellQ[m]),
            .padOut     (cellOut[m]),
            .padOe      (cellOe[m])
        );
    end

    // Configuration, fuse, signature and array writes
    always_comb begin
        cellMode_next = cellMode_reg;
        cellPol_next  = cellPol_reg;
        secured_next  = secured_reg;
        sig_next      = sig_reg;
        termTrue_next = termTrue_reg;
        termComp_next = termComp_reg;
        porCnt_next   = porBusy ? porCnt_reg + 1'b1 : porCnt_reg;
        if (wrEn) begin
            unique case (paddr)
                ADDR_CELL_MODE: cellMode_next = pwdata[CELL_COUNT-1:0];
                ADDR_CELL_POL:  cellPol_next  = pwdata[CELL_COUNT-1:0];
                // Fuse only sets; takes hold from the next cycle on
                ADDR_SECURE: begin
                    secured_next = secured_reg |
                                   pwdata[SECURE_FUSE_BIT];
                end
                ADDR_SIG_LO: sig_next[31:0]  = pwdata;
                ADDR_SIG_HI: sig_next[63:32] = pwdata;
                default: begin
                    if (isTermAddr(paddr) && !paddr[1] && !paddr[0]) begin
                        if (paddr[2]) begin
                            termComp_next[termIdx(paddr)] =
                                pwdata[SIG_COUNT-1:0];
                        end else begin
                            termTrue_next[termIdx(paddr)] =
                                pwdata[SIG_COUNT-1:0];
                        end
                    end
                end
            endcase
        end
    end

    // APB answer: data prepared in setup, ready in the access cycle
    always_comb begin
        prdata_next  = '0;
        pslverr_next = 1'b0;
        pready_next  = psel & ~penable;
        if (psel && !penable) begin
            unique case (paddr)
                ADDR_CELL_MODE: prdata_next[CELL_COUNT-1:0] = cellMode_reg;
                ADDR_CELL_POL:  prdata_next[CELL_COUNT-1:0] = cellPol_reg;
                ADDR_SECURE: prdata_next[SECURE_FUSE_BIT] = secured_reg;
                ADDR_PRELOAD: prdata_next = '0;
                ADDR_SIG_LO: prdata_next = sig_reg[31:0];
                ADDR_SIG_HI: prdata_next = sig_reg[63:32];
                ADDR_STATUS: begin
                    prdata_next[STATUS_Q_LSB +: CELL_COUNT]  = cellQ;
                    prdata_next[STATUS_OE_LSB +: CELL_COUNT] = cellOe;
                    prdata_next[STATUS_POR_BIT] = porBusy;
                    prdata_next[STATUS_SEC_BIT] = secured_reg;
                end
                ADDR_PINS: begin
                    prdata_next[PINS_IN_LSB +: IN_COUNT] = dinKept;
                    prdata_next[PINS_IO_LSB +: CELL_COUNT] = ioKept;
                end
                default: begin
                    if (isTermAddr(paddr) && !paddr[1] && !paddr[0]) begin
                        // Secured parts hide the pattern, no error
                        if (!secured_reg) begin
                            prdata_next[SIG_COUNT-1:0] = paddr[2] ?
                                termComp_reg[termIdx(paddr)] :
                                termTrue_reg[termIdx(paddr)];
                        end
                    end else begin
                        pslverr_next = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cellMode_reg <= CELL_MODE_RST;
            cellPol_reg  <= CELL_POL_RST;
            secured_reg  <= 1'b0;
            sig_reg      <= SIG_RST;
            porCnt_reg   <= '0;
            prdata_reg   <= '0;
            pready_reg   <= 1'b0;
            pslverr_reg  <= 1'b0;
            for (int t = 0; t < TERM_COUNT; t++) begin
                termTrue_reg[t] <= TERM_RST;
                termComp_reg[t] <= TERM_RST;
            end
        end else begin
            cellMode_reg <= cellMode_next;
            cellPol_reg  <= cellPol_next;
            secured_reg  <= secured_next;
            sig_reg      <= sig_next;
            porCnt_reg   <= porCnt_next;
            prdata_reg   <= prdata_next;
            pready_reg   <= pready_next;
            pslverr_reg  <= pslverr_next;
            termTrue_reg <= termTrue_next;
            termComp_reg <= termComp_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign ioOut   = cellOut;
    assign ioOe    = cellOe;

endmodule // macrocell_array

// ===== sim/macrocell_array_checker.sv
// Port-level assertions for the macrocell array.
// Assumes one clock domain and a bind onto macrocell_array.
module macrocell_array_checker
    import macrocell_pkg::*;
(
    input wire logic                  clk_sys,  // system clock
    input wire logic                  arst_n,   // async reset, low
    input wire logic [11:0]           paddr,    // APB address
    input wire logic                  psel,     // APB select
    input wire logic                  penable,  // APB enable
    input wire logic                  pwrite,   // APB direction
    input wire logic [31:0]           prdata,   // APB read data
    input wire logic                  pready,   // APB ready
    input wire logic                  pslverr,  // APB error
    input wire logic                  outEnPin, // driver enable pin
    input wire logic [CELL_COUNT-1:0] ioOut,    // I/O output levels
    input wire logic [CELL_COUNT-1:0] ioOe      // I/O output enables
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_ready_qual: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_rdata_idle: assert property (!pready |-> prdata == '0)
        else $error("read data outside access");
    chk_misaligned_err: assert property (
        psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
        else $error("misaligned access not refused");
    chk_reset_pins: assert property (
        $rose(arst_n) |-> ioOut == '0 && ioOe == '0)
        else $error("pins not clear after reset");
    chk_oe_pin_off: assert property (!outEnPin [*4] |-> ioOe == '0)
        else $error("driver on while enable pin low");
    chk_oe_pin_cause: assert property (
        |(ioOe & ~$past(ioOe)) |-> $past(outEnPin, 3))
        else $error("driver rose without enable pin");

    cover property (pready && pslverr);
    cover property (pready && pwrite);
    cover property ($rose(|ioOe));
    cover property ($rose(|ioOut));
endmodule // macrocell_array_checker

bind macrocell_array macrocell_array_checker chk (
    .clk_sys(clk_sys), .arst_n(arst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .outEnPin(outEnPin),
    .ioOut(ioOut), .ioOe(ioOe));

// ===== sim/board_model.sv
// Board around the array: pin drivers and the register clock pin.
// Assumes the bench sets levels and drive flags, and requests pulses.
module board_model
    import macrocell_pkg::*;
(
    input  wire logic                  clk_sys,   // system clock
    input  wire logic                  arst_n,    // reset, active low
    input  wire logic [IN_COUNT-1:0]   inSet,     // wanted input levels
    input  wire logic [IN_COUNT-1:0]   inDrv,     // inputs driven
    input  wire logic [CELL_COUNT-1:0] ioSet,     // wanted I/O levels
    input  wire logic [CELL_COUNT-1:0] ioDrv,     // I/O driven
    input  wire logic                  oeSet,     // enable pin level
    input  wire logic                  pulseReq,  // one clock pin pulse
    output logic      [IN_COUNT-1:0]   dinLevel,  // input pin levels
    output logic      [IN_COUNT-1:0]   dinDriven, // input pins driven
    output logic      [CELL_COUNT-1:0] ioLevel,   // I/O pin levels
    output logic      [CELL_COUNT-1:0] ioDriven,  // I/O pins driven
    output logic                       clkPin,    // register clock pin
    output logic                       outEnPin   // driver enable pin
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [IN_COUNT-1:0]   lastIn = '0;
    logic [CELL_COUNT-1:0] lastIo = '0;
    logic [4:0]            porCnt;
    logic [3:0]            phase;

    // Released lines show the inverse, so only a real keeper holds them
    assign dinLevel  = (inSet & inDrv) | (~lastIn & ~inDrv);
    assign ioLevel   = (ioSet & ioDrv) | (~lastIo & ~ioDrv);
    assign dinDriven = inDrv;
    assign ioDriven  = ioDrv;
    assign outEnPin  = oeSet;
    assign clkPin    = phase >= 4'd3 && phase <= 4'd5;

    always @(posedge clk_sys) begin
        lastIn <= (inSet & inDrv) | (lastIn & ~inDrv);
        lastIo <= (ioSet & ioDrv) | (lastIo & ~ioDrv);
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            porCnt <= '0;
            phase  <= '0;
        end else begin
            if (porCnt <= 5'(PWR_RESET_CYC + 1)) begin
                porCnt <= porCnt + 5'd1;
            end
            // Two quiet cycles before the edge cover input setup
            if (phase != 4'd0) begin
                phase <= (phase == 4'd8) ? 4'd0 : phase + 4'd1;
            end else if (pulseReq && porCnt > 5'(PWR_RESET_CYC + 1)) begin
                phase <= 4'd1;
            end
        end
    end
endmodule // board_model

// ===== sim/macrocell_array_tb.sv
// Self-checking bench for the macrocell array.
// Assumes APB answers with no wait states and pins settle in 6 cycles.
`define CHK(got, exp) \
    begin nChecks++; if ((got) !== (exp)) begin errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); end end
module macrocell_array_tb
    import macrocell_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic                  clk_sys = 1'b0;
    logic                  arst_n  = 1'b0;
    logic [11:0]           paddr   = '0;
    logic                  psel    = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite  = 1'b0;
    logic [31:0]           pwdata  = '0;
    logic [31:0]           prdata, rdVal;
    logic                  pready, pslverr, rdErr, clkPin, outEnPin;
    logic [IN_COUNT-1:0]   inSet = '0, inDrv = '1, dinLevel, dinDriven;
    logic [CELL_COUNT-1:0] ioSet = '0, ioDrv = '0, ioLevel, ioDriven;
    logic [CELL_COUNT-1:0] ioOut, ioOe;
    logic                  oeSet = 1'b1, pulseReq = 1'b0;
    int                    errors = 0, nChecks = 0;

    always #50 clk_sys = ~clk_sys;

    macrocell_array uut (.clk_sys(clk_sys), .arst_n(arst_n),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dinLevel(dinLevel), .dinDriven(dinDriven),
        .clkPin(clkPin), .outEnPin(outEnPin), .ioLevel(ioLevel),
        .ioDriven(ioDriven), .ioOut(ioOut), .ioOe(ioOe));

    board_model board (.clk_sys(clk_sys), .arst_n(arst_n), .inSet(inSet),
        .inDrv(inDrv), .ioSet(ioSet), .ioDrv(ioDrv), .oeSet(oeSet),
        .pulseReq(pulseReq), .dinLevel(dinLevel), .dinDriven(dinDriven),
        .ioLevel(ioLevel), .ioDriven(ioDriven), .clkPin(clkPin),
        .outEnPin(outEnPin));

    function automatic logic [11:0] termAddr(int t);
        return ADDR_TERM_BASE + 12'(t * 8);
    endfunction

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            $display("MISMATCH t=%0t no ready", $time);
        end
        rdVal = prdata;
        rdErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle();
        repeat (6) @(posedge clk_sys);
    endtask

    task automatic pulse();
        pulseReq <= 1'b1;
        @(posedge clk_sys);
        pulseReq <= 1'b0;
        repeat (12) @(posedge clk_sys);
    endtask

    task automatic final_report();
        $display("checks=%0d errors=%0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (12) @(posedge clk_sys);
        apb(1'b0, ADDR_CELL_MODE, '0); `CHK(rdVal[9:0], CELL_MODE_RST)
        apb(1'b0, ADDR_SIG_HI, '0);    `CHK(rdVal, SIG_RST[63:32])
        apb(1'b0, ADDR_STATUS, '0);    `CHK(rdVal, 32'h0)
        apb(1'b0, 12'h020, '0);        `CHK(rdErr, 1'b1)
        apb(1'b0, 12'h006, '0);        `CHK(rdErr, 1'b1)
        apb(1'b0, ADDR_SIG_LO, '0);    `CHK(rdErr, 1'b0)
        // Combinational cell 0 with an enable term on input 1
        apb(1'b1, termAddr(0), 32'h1);
        apb(1'b1, termAddr(80), 32'h2);
        inSet <= 12'h003;
        settle();
        `CHK(ioOut[0], 1'b1)
        `CHK(ioOe[0], 1'b1)
        inSet <= 12'h002;
        settle();
        `CHK(ioOut[0], 1'b0)
        apb(1'b1, ADDR_CELL_POL, 32'h1);
        settle();
        `CHK(ioOut[0], 1'b1)
        inSet <= 12'h000;
        settle();
        `CHK(ioOe[0], 1'b0)
        inSet <= 12'h002;
        oeSet <= 1'b0;
        settle();
        `CHK(ioOe[0], 1'b0)
        oeSet <= 1'b1;
        // Registered cell 1: cleared state shows through the polarity
        apb(1'b1, ADDR_CELL_MODE, 32'h2);
        apb(1'b1, ADDR_CELL_POL, 32'h2);
        settle();
        `CHK(ioOut[1], 1'b1)
        apb(1'b1, ADDR_CELL_POL, 32'h0);
        apb(1'b1, termAddr(8), 32'h1);
        apb(1'b1, termAddr(90), 32'h8);
        apb(1'b1, termAddr(91), 32'h4);
        inSet <= 12'h003;
        settle();
        `CHK(ioOut[1], 1'b0)
        pulse();
        `CHK(ioOut[1], 1'b1)
        inSet <= 12'h002;
        pulse();
        `CHK(ioOut[1], 1'b0)
        inSet <= 12'h006;
        pulse();
        `CHK(ioOut[1], 1'b1)
        inSet <= 12'h00a;
        settle();
        `CHK(ioOut[1], 1'b0)
        inSet <= 12'h002;
        apb(1'b1, ADDR_PRELOAD, 32'h0002_0002);
        apb(1'b0, ADDR_STATUS, '0); `CHK(rdVal[1], 1'b1)
        apb(1'b1, ADDR_PRELOAD, 32'h0002_0000);
        apb(1'b0, ADDR_STATUS, '0); `CHK(rdVal[1], 1'b0)
        // Keepers on an input and on an I/O pin
        inSet <= 12'h012;
        ioSet <= 10'h200;
        ioDrv <= 10'h200;
        settle();
        inDrv <= 12'hfef;
        ioDrv <= 10'h000;
        settle();
        apb(1'b0, ADDR_PINS, '0);
        `CHK(rdVal[4], 1'b1)
        `CHK(rdVal[21], 1'b1)
        inSet <= 12'h002;
        inDrv <= 12'hfff;
        settle();
        apb(1'b0, ADDR_PINS, '0); `CHK(rdVal[4], 1'b0)
        // Signature, then the fuse as the very last configuration step
        apb(1'b1, ADDR_SIG_LO, 32'h5a5a_0f0f);
        apb(1'b1, ADDR_SECURE, 32'h1);
        apb(1'b0, ADDR_STATUS, '0); `CHK(rdVal[21], 1'b1)
        apb(1'b0, termAddr(8), '0); `CHK(rdVal, 32'h0)
        apb(1'b1, ADDR_PRELOAD, 32'h0002_0002);
        apb(1'b0, ADDR_STATUS, '0); `CHK(rdVal[1], 1'b0)
        apb(1'b0, ADDR_SIG_LO, '0); `CHK(rdVal, 32'h5a5a_0f0f)
        final_report();
    end
endmodule // macrocell_array_tb
